// >>> rtl/psr_regs.vh
// Constants for the scan reconfiguration controller
`ifndef PSR_REGS_VH
`define PSR_REGS_VH
`define PSR_CHAIN_LEN     144
`define PSR_CNT_W         8
`define PSR_DIV_HALF      8'h02
`define PSR_DONE_TIMEOUT  16'hffff
`define PSR_RST_CYCLES    8'h04
`define PSR_LAST_BIT      8'h8f
`define PSR_ADDR_W        8
`define PSR_DATA_W        9
`define PSR_ST_IDLE       3'h0
`define PSR_ST_SHIFT      3'h1
`define PSR_ST_UPDATE     3'h2
`define PSR_ST_WAITDONE   3'h3
`define PSR_ST_RESET      3'h4
`define PSR_ST_CACHEOP    3'h5
`endif

// >>> rtl/psr_sync.v
// Two-flop synchroniser for a single level from another domain
module psr_sync (
    input  wire sys_clk,
    input  wire reset,
    input  wire async_in,
    output reg  sync_out
);
    reg stage1;

    always @(posedge sys_clk) begin
        if (reset) begin
            stage1   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// >>> rtl/psr_ctrl.v
// Scan-chain PLL reconfiguration controller with settings cache
`include "psr_regs.vh"

module psr_ctrl (
    input  wire        sys_clk,
    input  wire        reset,
    input  wire        reload_req,
    input  wire        reset_req,
    input  wire        cache_write,
    input  wire        cache_read,
    input  wire [7:0]  cache_addr,
    input  wire [8:0]  cache_wdata,
    input  wire        scan_done_in,
    input  wire        scan_readback_in,
    output reg  [8:0]  cache_rdata,
    output reg  [143:0] readback_word,
    output reg         busy,
    output reg         pll_reset,
    output reg         pll_config_update,
    output reg         pll_scan_clk,
    output reg         pll_scan_clk_en,
    output reg         pll_scan_data
);
    reg [143:0] cache;
    reg [2:0]   state;
    reg [7:0]   bit_idx;
    reg [7:0]   div_cnt;
    reg [7:0]   rst_cnt;
    reg [15:0]  wait_cnt;
    reg         scan_done_meta;
    wire        scan_done_s;
    wire        readback_s;
    wire        scan_rise;
    wire        scan_fall;
    wire        done_rise;
    wire        shift_step;

    // Controller states
    localparam [2:0] ST_IDLE     = `PSR_ST_IDLE;
    localparam [2:0] ST_SHIFT    = `PSR_ST_SHIFT;
    localparam [2:0] ST_UPDATE   = `PSR_ST_UPDATE;
    localparam [2:0] ST_WAITDONE = `PSR_ST_WAITDONE;
    localparam [2:0] ST_RESET    = `PSR_ST_RESET;
    localparam [2:0] ST_CACHEOP  = `PSR_ST_CACHEOP;

    // Last count of a scan clock half period
    function div_last;
        input [7:0] c;
        begin
            div_last = (c == `PSR_DIV_HALF - 8'h01);
        end
    endfunction

    // Eight-bit counter step shared by the divider, chain index and reset timer
    function [7:0] inc8;
        input [7:0] v;
        begin
            inc8 = v + 8'h01;
        end
    endfunction

    // Clamp a bit index into the chain so a stray address cannot run off the end
    function [7:0] bit_pos;
        input [7:0] a;
        begin
            if (a > `PSR_LAST_BIT)
                bit_pos = `PSR_LAST_BIT;
            else
                bit_pos = a;
        end
    endfunction

    psr_sync u_done (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in (scan_done_in),
        .sync_out (scan_done_s)
    );

    psr_sync u_rdbk (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in (scan_readback_in),
        .sync_out (readback_s)
    );

    assign scan_rise  = div_last(div_cnt) && !pll_scan_clk;
    assign scan_fall  = div_last(div_cnt) && pll_scan_clk;
    assign shift_step = (state == ST_SHIFT) && scan_rise && pll_scan_clk_en;
    // Edge of the synchronised flag; the first stage is never read here
    assign done_rise  = scan_done_s && !scan_done_meta;

    // Scan clock is a free-running divider; the enable gates its effect in the PLL,
    // so the divider never has to restart in phase with a request
    always @(posedge sys_clk) begin
        if (reset) begin
            div_cnt      <= 8'h00;
            pll_scan_clk <= 1'b0;
        end else if (div_last(div_cnt)) begin
            div_cnt      <= 8'h00;
            pll_scan_clk <= !pll_scan_clk;
        end else begin
            div_cnt <= inc8(div_cnt);
        end
    end

    // Previous synchronised level for edge detection
    always @(posedge sys_clk) begin
        if (reset)
            scan_done_meta <= 1'b0;
        else
            scan_done_meta <= scan_done_s;
    end

    // Capture runs on the same scan edges as the shift, so the word ends up
    // holding the chain as it stood before this reload
    always @(posedge sys_clk) begin
        if (reset)
            readback_word <= {`PSR_CHAIN_LEN{1'b0}};
        else if (shift_step)
            readback_word <= {readback_s, readback_word[`PSR_CHAIN_LEN-1:1]};
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            cache             <= {`PSR_CHAIN_LEN{1'b0}};
            cache_rdata       <= 9'h000;
            state             <= ST_IDLE;
            bit_idx           <= 8'h00;
            rst_cnt           <= 8'h00;
            wait_cnt          <= 16'h0000;
            busy              <= 1'b0;
            pll_reset         <= 1'b0;
            pll_config_update <= 1'b0;
            pll_scan_clk_en   <= 1'b0;
            pll_scan_data     <= 1'b0;
        end else begin
            pll_config_update <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // A level request resets the PLL at once, even while idle
                    pll_reset <= reset_req;
                    busy      <= 1'b0;
                    if (reload_req) begin
                        busy     <= 1'b1;
                        bit_idx  <= 8'h00;
                        state    <= `PSR_ST_SHIFT;
                    end else if (cache_write || cache_read) begin
                        busy  <= 1'b1;
                        state <= `PSR_ST_CACHEOP;
                        if (cache_write)
                            cache[bit_pos(cache_addr)] <= cache_wdata[0];
                        cache_rdata <= {8'h00, cache[bit_pos(cache_addr)]};
                    end
                end
                // One busy cycle is enough: the cache is plain flip-flops
                ST_CACHEOP: begin
                    busy  <= 1'b0;
                    state <= `PSR_ST_IDLE;
                end
                ST_SHIFT: begin
                    pll_reset <= reset_req;
                    busy      <= 1'b1;
                    // Data changes on the falling edge so the PLL samples it stable
                    if (scan_fall) begin
                        pll_scan_clk_en <= 1'b1;
                        pll_scan_data   <= cache[bit_idx];
                    end
                    if (shift_step) begin
                        if (bit_idx == `PSR_LAST_BIT) begin
                            state <= ST_UPDATE;
                        end else begin
                            bit_idx <= inc8(bit_idx);
                        end
                    end
                end
                ST_UPDATE: begin
                    if (scan_fall) begin
                        pll_scan_clk_en   <= 1'b0;
                        pll_config_update <= 1'b1;
                        wait_cnt          <= 16'h0000;
                        state             <= `PSR_ST_WAITDONE;
                    end
                end
                ST_WAITDONE: begin
                    wait_cnt <= wait_cnt + 16'h0001;
                    // Timeout guards against a PLL that never reports completion
                    if (done_rise || wait_cnt == `PSR_DONE_TIMEOUT) begin
                        pll_reset <= 1'b1;
                        rst_cnt   <= 8'h00;
                        state     <= `PSR_ST_RESET;
                    end
                end
                ST_RESET: begin
                    rst_cnt <= inc8(rst_cnt);
                    if (rst_cnt == `PSR_RST_CYCLES - 8'h01) begin
                        // A held request keeps the PLL in reset past the pulse
                        pll_reset <= reset_req;
                        // Busy drops with the state, so idle never sees busy high
                        busy      <= 1'b0;
                        state     <= ST_IDLE;
                    end
                end
                default: begin
                    state <= `PSR_ST_IDLE;
                end
            endcase
        end
    end
endmodule

// >>> sim/psr_ctrl_props.sv
// Port checks for the scan reconfiguration controller
module psr_ctrl_props (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic reload_req,
    input wire logic reset_req,
    input wire logic cache_write,
    input wire logic cache_read,
    input wire logic busy,
    input wire logic pll_reset,
    input wire logic pll_config_update,
    input wire logic pll_scan_clk,
    input wire logic pll_scan_clk_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_half;
        pll_scan_clk[*2] ##1 !pll_scan_clk[*2];
    endsequence
    a_busy_follows: assert property (!busy && reload_req |=> busy)
        else $error("busy late");
    a_busy_cause: assert property ($rose(busy) |-> $past(reload_req | cache_write | cache_read))
        else $error("busy without cause");
    a_update_single: assert property (pll_config_update |=> !pll_config_update)
        else $error("update too long");
    a_update_busy: assert property (pll_config_update |-> busy)
        else $error("update when idle");
    a_gate_busy: assert property (pll_scan_clk_en |-> busy)
        else $error("gate when idle");
    a_rst_request: assert property (reset_req && !busy |=> pll_reset)
        else $error("no pll reset");
    a_rst_quiet: assert property (!busy && !pll_reset && !reset_req |=> !pll_reset)
        else $error("stray pll reset");
    a_scan_div: assert property ($rose(pll_scan_clk) |-> s_half ##1 pll_scan_clk)
        else $error("scan clock period");
    a_busy_end: assert property ($fell(busy) |-> !pll_reset)
        else $error("busy ended early");
endmodule
bind psr_ctrl psr_ctrl_props u_props (.sys_clk, .reset, .reload_req, .reset_req,
    .cache_write, .cache_read, .busy, .pll_reset, .pll_config_update, .pll_scan_clk,
    .pll_scan_clk_en);

// >>> sim/psr_pll_model.sv
// Behavioural PLL scan chain with a delayed completion flag
module psr_pll_model (
    input  wire logic sys_clk,
    input  wire logic scan_clk,
    input  wire logic clk_en,
    input  wire logic scan_data,
    input  wire logic cfg_update,
    input  wire logic pll_rst,
    output logic      scan_done,
    output logic      readback
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [143:0] chain = '0;
    int           cnt = 0;
    initial scan_done = 1'b0;
    always @(posedge scan_clk) if (clk_en) chain <= {scan_data, chain[143:1]};
    // Line shows the outgoing bit; it only moves while the gate is open
    assign readback = chain[0];
    always @(posedge sys_clk) begin
        if (pll_rst) scan_done <= 1'b0;
        else if (cfg_update) cnt <= 9;
        else if (cnt > 0) begin
            cnt <= cnt - 1;
            scan_done <= (cnt == 1);
        end
    end
endmodule

// >>> sim/test_pll_scan_reconfig_control.sv
// Random self-checking bench for the scan reconfiguration controller
module test_pll_scan_reconfig_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, reset = 1, reload_req = 0, reset_req = 0, cache_write = 0;
    logic cache_read = 0, busy, pll_reset, pll_config_update, pll_scan_clk;
    logic pll_scan_clk_en, pll_scan_data, scan_done, readback;
    logic [7:0] cache_addr = 0;
    logic [8:0] cache_wdata = 0, cache_rdata;
    logic [143:0] exp_bits, readback_word;
    int n_errors = 0, comparisons = 0, n, i, n_upd = 0;
    psr_ctrl DUT (.sys_clk, .reset, .reload_req, .reset_req, .cache_write, .cache_read,
        .cache_addr, .cache_wdata, .scan_done_in(scan_done), .scan_readback_in(readback),
        .cache_rdata, .readback_word, .busy, .pll_reset, .pll_config_update,
        .pll_scan_clk, .pll_scan_clk_en, .pll_scan_data);
    psr_pll_model u_pll (.sys_clk, .scan_clk(pll_scan_clk), .clk_en(pll_scan_clk_en),
        .scan_data(pll_scan_data), .cfg_update(pll_config_update), .pll_rst(pll_reset),
        .scan_done, .readback);
    initial forever #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (pll_config_update === 1'b1) n_upd++;
    task chk(string s, logic [143:0] e, logic [143:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask
    task end_of_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Kind 0 writes, 1 reads, 2 reloads; a reload also gets a refused repeat
    task op(int k, int a);
        logic [8:0] w;
        w = $urandom;
        @(posedge sys_clk);
        cache_addr <= a;
        cache_wdata <= w;
        {cache_write, cache_read, reload_req} <= {k == 0, k == 1, k == 2};
        if (k == 0) exp_bits[a] = w[0];
        @(posedge sys_clk);
        {cache_write, cache_read, reload_req} <= 3'h0;
        @(negedge sys_clk);
        chk("busy", 1, busy);
        if (k == 2) begin
            @(posedge sys_clk) reload_req <= 1'b1;
            @(posedge sys_clk) reload_req <= 1'b0;
        end
        for (n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge sys_clk);
        if (n == 3000) begin
            n_errors++;
            end_of_test;
        end
        if (k == 1) chk("rdata", {8'h00, exp_bits[a]}, cache_rdata);
        repeat (3) @(negedge sys_clk);
        chk("idle", 0, busy);
    endtask
    initial begin
        void'($urandom(32'h8e23fcd3));
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        for (i = 0; i < 144; i++) op(0, i);
        for (i = 0; i < 2; i++) begin
            op(2, 0);
            chk("chain", exp_bits, u_pll.chain);
            chk("readback", (i == 0) ? 144'h0 : exp_bits, readback_word);
            chk("updates", i + 1, n_upd);
        end
        for (i = 0; i < 144; i += 13) op(1, i);
        op(1, 143);
        @(posedge sys_clk) reset_req <= 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("pll_reset", 1, pll_reset);
        @(posedge sys_clk) reset_req <= 1'b0;
        repeat (20) @(posedge sys_clk);
        end_of_test;
    end
endmodule
